// file: hdl/apb_axis_param_bank.sv
// axis parameter bank: command/data port writes, counters, limits, compares
// Behaviour
// - decel point used only in fixed-pulse accel drive with manual decel bit set
// - output pulses are |target| relative, |target - logical count| absolute
// - logical counter loads by 09h, counts up/down with direction pulses
// - logical counter writable anytime, read anytime by 30h
// - real counter loads by 0ah, follows encoder pulses
// - real counter writable anytime, read anytime by 31h
// - command 0bh loads upper software limit
// - command 0ch loads lower software limit, both writable anytime
// - limit enable, object and stop mode come from limit config port
// - accel offset clears to zero at reset
// - command 0eh sets logical ring maximum
// - command 0fh sets real ring maximum
// - both ring maximums reset to all ones
// - four compare registers load by 10h-13h, read by 34h-37h
// - compare results drive compare output and sync triggers
// - homing low speed, command 14h, used in homing steps two and three
module apb_axis_param_bank
    import apb_pkg::*;
(
    input  wire logic        i_clk_sys,          // 200 mhz clock
    input  wire logic        i_arst_n,           // async reset, active low
    input  wire logic [15:0] i_data_low_port,    // low data word
    input  wire logic [15:0] i_data_high_port,   // high data word
    input  wire logic [7:0]  i_command_port,     // command code
    input  wire logic        i_command_wr,       // command write strobe, 1 cycle
    input  wire logic [15:0] i_limit_config_port,// limit enable/object/stop bits
    input  wire logic [15:0] i_mode_config_port, // mode bits, bit0 manual decel
    input  wire logic        i_pulse_plus,       // plus direction output pulse
    input  wire logic        i_pulse_minus,      // minus direction output pulse
    input  wire logic        i_enc_up,           // encoder up pulse pin
    input  wire logic        i_enc_dn,           // encoder down pulse pin
    input  wire logic        i_fixed_drive,      // fixed pulse accel drive active
    input  wire logic        i_abs_mode,         // absolute position drive
    input  wire logic [31:0] i_target_pulses,    // signed target setting
    input  wire logic        i_drive_start,      // drive start pulse
    input  wire logic [1:0]  i_homing_step,      // active homing step, 0 idle
    input  wire logic [31:0] i_compare_src,      // value compared to match regs
    output logic [31:0]      o_read_data,        // data for read commands
    output logic             o_read_valid,       // read data ready, 1 cycle
    output logic             o_decel_now,        // manual decel point reached
    output logic [31:0]      o_output_pulses,    // pulses of the fixed drive
    output logic [31:0]      o_arc_center,       // arc centre point
    output logic [31:0]      o_limit_upper,      // upper software limit
    output logic [31:0]      o_limit_lower,      // lower software limit
    output logic [15:0]      o_limit_config,     // latched limit config
    output logic [15:0]      o_accel_offset,     // accel counter offset
    output logic [31:0]      o_homing_speed,     // homing low speed in steps two and three, else zero
    output logic [3:0]       o_match_hit,        // compare results
    output logic             o_match_trig        // compare rising trigger
);
    import apb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    apb_word_t decel_start_point_reg, decel_start_point_next;
    apb_word_t arc_center_point_reg,  arc_center_point_next;
    apb_word_t soft_limit_upper_reg,  soft_limit_upper_next;
    apb_word_t soft_limit_lower_reg,  soft_limit_lower_next;
    logic [15:0] accel_count_offset_reg, accel_count_offset_next;
    apb_word_t logical_ring_max_reg,  logical_ring_max_next;
    apb_word_t real_ring_max_reg,     real_ring_max_next;
    apb_word_t homing_low_speed_reg,  homing_low_speed_next;
    apb_word_t match_value_reg  [NUM_MATCH];
    apb_word_t match_value_next [NUM_MATCH];
    logic [15:0] limit_cfg_reg, limit_cfg_next;
    apb_word_t rd_reg, rd_next;
    logic      rdv_reg, rdv_next;
    apb_word_t pulses_reg, pulses_next;
    apb_word_t sent_reg, sent_next;
    logic      decel_reg, decel_next;
    apb_word_t hspd_reg, hspd_next;
    logic [3:0] hit_reg, hit_next;
    logic       trig_reg, trig_next;

    apb_word_t wdata;
    logic      enc_up_rise, enc_dn_rise;
    apb_word_t diff;

    assign wdata = {i_data_high_port, i_data_low_port};

    apb_cnt_if lp_if ();
    apb_cnt_if rp_if ();

    ////////////////////////////////////////////////////////////////////////////
    // counters
    assign lp_if.load     = i_command_wr && i_command_port == CMD_LOGICAL_POS;
    assign lp_if.load_val = wdata;
    assign lp_if.step_up  = i_pulse_plus;
    assign lp_if.step_dn  = i_pulse_minus;
    assign lp_if.ring_max = logical_ring_max_reg;

    apb_sync3 u_enc_up (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_async   (i_enc_up),
        .o_level   (),
        .o_rise    (enc_up_rise)
    );
    apb_sync3 u_enc_dn (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_async   (i_enc_dn),
        .o_level   (),
        .o_rise    (enc_dn_rise)
    );

    assign rp_if.load     = i_command_wr && i_command_port == CMD_REAL_POS;
    assign rp_if.load_val = wdata;
    assign rp_if.step_up  = enc_up_rise;
    assign rp_if.step_dn  = enc_dn_rise;
    assign rp_if.ring_max = real_ring_max_reg;

    apb_ring_counter u_lp (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .cnt       (lp_if)
    );
    apb_ring_counter u_rp (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .cnt       (rp_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command write decode and readback
    always_comb begin
        decel_start_point_next  = decel_start_point_reg;
        arc_center_point_next   = arc_center_point_reg;
        soft_limit_upper_next   = soft_limit_upper_reg;
        soft_limit_lower_next   = soft_limit_lower_reg;
        accel_count_offset_next = accel_count_offset_reg;
        logical_ring_max_next   = logical_ring_max_reg;
        real_ring_max_next      = real_ring_max_reg;
        homing_low_speed_next   = homing_low_speed_reg;
        for (int i = 0; i < NUM_MATCH; i++) begin
            match_value_next[i] = match_value_reg[i];
        end
        limit_cfg_next = i_limit_config_port;
        rd_next  = rd_reg;
        rdv_next = 1'b0;
        if (i_command_wr) begin
            case (i_command_port)
                CMD_DECEL_POINT:  decel_start_point_next  = wdata;
                CMD_ARC_CENTER:   arc_center_point_next   = wdata;
                CMD_LIMIT_UPPER:  soft_limit_upper_next   = wdata;
                CMD_LIMIT_LOWER:  soft_limit_lower_next   = wdata;
                CMD_ACCEL_OFFSET: accel_count_offset_next = i_data_low_port;
                CMD_LOGICAL_MAX:  logical_ring_max_next   = wdata;
                CMD_REAL_MAX:     real_ring_max_next      = wdata;
                CMD_HOMING_SPEED: homing_low_speed_next   = wdata;
                CMD_RD_LOGICAL: begin
                    rd_next  = lp_if.count;
                    rdv_next = 1'b1;
                end
                CMD_RD_REAL: begin
                    rd_next  = rp_if.count;
                    rdv_next = 1'b1;
                end
                default: begin
                    if (i_command_port[7:2] == CMD_MATCH_BASE[7:2]) begin
                        match_value_next[i_command_port[1:0]] = wdata;
                    end else if (i_command_port[7:2] == CMD_RD_MATCH[7:2]) begin
                        rd_next  = match_value_reg[i_command_port[1:0]];
                        rdv_next = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            decel_start_point_reg  <= WORD_RESET;
            arc_center_point_reg   <= WORD_RESET;
            soft_limit_upper_reg   <= WORD_RESET;
            soft_limit_lower_reg   <= WORD_RESET;
            accel_count_offset_reg <= ACCEL_OFS_RESET;
            logical_ring_max_reg   <= RING_MAX_RESET;
            real_ring_max_reg      <= RING_MAX_RESET;
            homing_low_speed_reg   <= WORD_RESET;
            for (int i = 0; i < NUM_MATCH; i++) begin
                match_value_reg[i] <= WORD_RESET;
            end
            limit_cfg_reg <= 16'h0000;
            rd_reg        <= WORD_RESET;
            rdv_reg       <= 1'b0;
        end else begin
            decel_start_point_reg  <= decel_start_point_next;
            arc_center_point_reg   <= arc_center_point_next;
            soft_limit_upper_reg   <= soft_limit_upper_next;
            soft_limit_lower_reg   <= soft_limit_lower_next;
            accel_count_offset_reg <= accel_count_offset_next;
            logical_ring_max_reg   <= logical_ring_max_next;
            real_ring_max_reg      <= real_ring_max_next;
            homing_low_speed_reg   <= homing_low_speed_next;
            for (int i = 0; i < NUM_MATCH; i++) begin
                match_value_reg[i] <= match_value_next[i];
            end
            limit_cfg_reg <= limit_cfg_next;
            rd_reg        <= rd_next;
            rdv_reg       <= rdv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fixed drive pulse count, manual decel, homing speed, compares
    always_comb begin
        diff        = i_abs_mode ? (i_target_pulses - lp_if.count) : i_target_pulses;
        pulses_next = pulses_reg;
        sent_next   = sent_reg;
        if (i_drive_start) begin
            pulses_next = diff[31] ? (32'h00000000 - diff) : diff;
            sent_next   = WORD_RESET;
        end else if (i_pulse_plus ^ i_pulse_minus) begin
            sent_next = sent_reg + 32'h00000001;
        end
        decel_next = i_fixed_drive && i_mode_config_port[MODE_MANUAL_DECEL_BIT]
                     && !i_drive_start && (sent_reg >= decel_start_point_reg);
        hspd_next  = (i_homing_step == 2'h2 || i_homing_step == 2'h3)
                     ? homing_low_speed_reg : WORD_RESET;
        for (int i = 0; i < NUM_MATCH; i++) begin
            hit_next[i] = $signed(i_compare_src) >= $signed(match_value_reg[i]);
        end
        trig_next = |(hit_next & ~hit_reg);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulses_reg <= WORD_RESET;
            sent_reg   <= WORD_RESET;
            decel_reg  <= 1'b0;
            hspd_reg   <= WORD_RESET;
            hit_reg    <= 4'h0;
            trig_reg   <= 1'b0;
        end else begin
            pulses_reg <= pulses_next;
            sent_reg   <= sent_next;
            decel_reg  <= decel_next;
            hspd_reg   <= hspd_next;
            hit_reg    <= hit_next;
            trig_reg   <= trig_next;
        end
    end

    assign o_read_data     = rd_reg;
    assign o_read_valid    = rdv_reg;
    assign o_decel_now     = decel_reg;
    assign o_output_pulses = pulses_reg;
    assign o_arc_center    = arc_center_point_reg;
    assign o_limit_upper   = soft_limit_upper_reg;
    assign o_limit_lower   = soft_limit_lower_reg;
    assign o_limit_config  = limit_cfg_reg;
    assign o_accel_offset  = accel_count_offset_reg;
    assign o_homing_speed  = hspd_reg;
    assign o_match_hit     = hit_reg;
    assign o_match_trig    = trig_reg;
endmodule

// file: hdl/apb_cnt_if.sv
// interface carrying one position counter's controls between modules
interface apb_cnt_if;
    import apb_pkg::*;
    logic      load;
    apb_word_t load_val;
    logic      step_up;
    logic      step_dn;
    apb_word_t ring_max;
    apb_word_t count;
    modport ctl (output load, output load_val, output step_up, output step_dn,
                 output ring_max, input count);
    modport cnt (input load, input load_val, input step_up, input step_dn,
                 input ring_max, output count);
endinterface

// file: hdl/apb_pkg.sv
// package: command codes, reset values, widths for the axis parameter bank
package apb_pkg;
    localparam logic [7:0]  CMD_DECEL_POINT  = 8'h07;
    localparam logic [7:0]  CMD_ARC_CENTER   = 8'h08;
    localparam logic [7:0]  CMD_LOGICAL_POS  = 8'h09;
    localparam logic [7:0]  CMD_REAL_POS     = 8'h0a;
    localparam logic [7:0]  CMD_LIMIT_UPPER  = 8'h0b;
    localparam logic [7:0]  CMD_LIMIT_LOWER  = 8'h0c;
    localparam logic [7:0]  CMD_ACCEL_OFFSET = 8'h0d;
    localparam logic [7:0]  CMD_LOGICAL_MAX  = 8'h0e;
    localparam logic [7:0]  CMD_REAL_MAX     = 8'h0f;
    localparam logic [7:0]  CMD_MATCH_BASE   = 8'h10;
    localparam logic [7:0]  CMD_HOMING_SPEED = 8'h14;
    localparam logic [7:0]  CMD_RD_LOGICAL   = 8'h30;
    localparam logic [7:0]  CMD_RD_REAL      = 8'h31;
    localparam logic [7:0]  CMD_RD_MATCH     = 8'h34;
    localparam int          NUM_MATCH        = 4;
    localparam logic [31:0] RING_MAX_RESET   = 32'hffffffff;
    localparam logic [15:0] ACCEL_OFS_RESET  = 16'h0000;
    localparam logic [31:0] WORD_RESET       = 32'h00000000;
    localparam int          MODE_MANUAL_DECEL_BIT = 0;
    typedef logic [31:0] apb_word_t;
endpackage

// file: hdl/apb_ring_counter.sv
// position counter with load, up/down step and optional ring wrap
module apb_ring_counter
    import apb_pkg::*;
(
    input  wire logic i_clk_sys,   // system clock
    input  wire logic i_arst_n,    // async reset, active low
    apb_cnt_if.cnt    cnt          // counter controls
);
    import apb_pkg::*;
    apb_word_t count_reg;
    apb_word_t count_next;
    logic      ring_on;

    assign cnt.count = count_reg;

    always_comb begin
        ring_on    = (cnt.ring_max != RING_MAX_RESET);
        count_next = count_reg;
        if (cnt.load) begin
            count_next = cnt.load_val;
        end else if (cnt.step_up && !cnt.step_dn) begin
            if (ring_on && count_reg == cnt.ring_max) begin
                count_next = WORD_RESET;
            end else begin
                count_next = count_reg + 32'h00000001;
            end
        end else if (cnt.step_dn && !cnt.step_up) begin
            if (ring_on && count_reg == WORD_RESET) begin
                count_next = cnt.ring_max;
            end else begin
                count_next = count_reg - 32'h00000001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_reg <= WORD_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// file: hdl/apb_sync3.sv
// three-flop synchroniser, change accepted when stages two and three agree
module apb_sync3 (
    input  wire logic i_clk_sys,   // system clock
    input  wire logic i_arst_n,    // async reset, active low
    input  wire logic i_async,     // pin level
    output logic      o_level,     // filtered level
    output logic      o_rise       // one-cycle pulse on accepted rise
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic       lvl_reg;
    logic       lvl_next;

    always_comb begin
        sh_next  = {sh_reg[1:0], i_async};
        lvl_next = lvl_reg;
        if (sh_reg[1] == sh_reg[2]) begin
            lvl_next = sh_reg[2];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sh_reg  <= 3'h0;
            lvl_reg <= 1'b0;
        end else begin
            sh_reg  <= sh_next;
            lvl_reg <= lvl_next;
        end
    end

    assign o_level = lvl_reg;
    assign o_rise  = lvl_next & ~lvl_reg;
endmodule

// file: verification/apb_bank_chk.sv
// checker: port-level assertions for the axis parameter bank
module apb_bank_chk
    import apb_pkg::*;
(
    input  wire logic        i_clk_sys,           // system clock
    input  wire logic        i_arst_n,            // async reset, active low
    input  wire logic [15:0] i_data_low_port,     // low data word
    input  wire logic [15:0] i_data_high_port,    // high data word
    input  wire logic [7:0]  i_command_port,      // command code
    input  wire logic        i_command_wr,        // command strobe
    input  wire logic [15:0] i_limit_config_port, // limit config
    input  wire logic [15:0] i_mode_config_port,  // mode bits
    input  wire logic        i_fixed_drive,       // fixed drive active
    input  wire logic [1:0]  i_homing_step,       // homing step
    input  wire logic        o_read_valid,        // read strobe
    input  wire logic        o_decel_now,         // decel flag
    input  wire logic [31:0] o_limit_upper,       // upper limit
    input  wire logic [31:0] o_limit_lower,       // lower limit
    input  wire logic [15:0] o_limit_config,      // latched config
    input  wire logic [15:0] o_accel_offset,      // accel offset
    input  wire logic [31:0] o_homing_speed       // homing speed
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    logic        rd_cmd;
    logic [31:0] wr_word;
    assign rd_cmd  = i_command_wr && (i_command_port inside {CMD_RD_LOGICAL, CMD_RD_REAL,
        CMD_RD_MATCH, CMD_RD_MATCH + 8'h01, CMD_RD_MATCH + 8'h02, CMD_RD_MATCH + 8'h03});
    assign wr_word = {i_data_high_port, i_data_low_port};

    a_read_answer: assert property (rd_cmd |=> o_read_valid)
        else $error("read command not answered");
    a_read_cause: assert property (o_read_valid |-> $past(rd_cmd))
        else $error("read strobe without read command");
    a_upper_load: assert property (i_command_wr && i_command_port == CMD_LIMIT_UPPER
        |=> o_limit_upper == $past(wr_word)) else $error("upper limit not loaded");
    a_lower_load: assert property (i_command_wr && i_command_port == CMD_LIMIT_LOWER
        |=> o_limit_lower == $past(wr_word)) else $error("lower limit not loaded");
    a_cfg_follow: assert property (1'b1 |=> o_limit_config == $past(i_limit_config_port))
        else $error("limit config not tracked");
    a_ofs_load: assert property (i_command_wr && i_command_port == CMD_ACCEL_OFFSET
        |=> o_accel_offset == $past(i_data_low_port)) else $error("offset not loaded");
    a_ofs_reset: assert property ($rose(i_arst_n) |-> o_accel_offset == ACCEL_OFS_RESET)
        else $error("offset not cleared by reset");
    a_homing_idle: assert property (i_homing_step < 2'd2 |=> o_homing_speed == 32'h0)
        else $error("homing speed outside steps two and three");
    a_decel_gate: assert property (o_decel_now
        |-> $past(i_fixed_drive && i_mode_config_port[MODE_MANUAL_DECEL_BIT]))
        else $error("decel flag without manual decel fixed drive");
    c_read: cover property (rd_cmd ##1 o_read_valid);
    c_decel: cover property (o_decel_now);
    c_homing: cover property (i_homing_step == 2'd2 ##1 o_homing_speed != 32'h0);
endmodule

bind apb_axis_param_bank apb_bank_chk u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_data_low_port(i_data_low_port), .i_data_high_port(i_data_high_port),
    .i_command_port(i_command_port), .i_command_wr(i_command_wr),
    .i_limit_config_port(i_limit_config_port), .i_mode_config_port(i_mode_config_port),
    .i_fixed_drive(i_fixed_drive), .i_homing_step(i_homing_step),
    .o_read_valid(o_read_valid), .o_decel_now(o_decel_now), .o_limit_upper(o_limit_upper),
    .o_limit_lower(o_limit_lower), .o_limit_config(o_limit_config),
    .o_accel_offset(o_accel_offset), .o_homing_speed(o_homing_speed));

// file: verification/apb_host_model.sv
// host model: drives command and data ports, collects read answers
module apb_host_model (
    input  wire logic        i_clk_sys,    // system clock
    input  wire logic [31:0] i_read_data,  // read answer
    input  wire logic        i_read_valid, // read strobe
    output logic      [15:0] o_data_low,   // low data word
    output logic      [15:0] o_data_high,  // high data word
    output logic      [7:0]  o_command,    // command code
    output logic             o_command_wr  // command strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_data_low, o_data_high, o_command, o_command_wr} = '0;
    end
    // data one edge ahead of the code, then a released idle cycle before the next access
    task automatic issue(input logic [7:0] code, input logic [31:0] data);
        @(posedge i_clk_sys);
        o_data_low   <= data[15:0];
        o_data_high  <= data[31:16];
        @(posedge i_clk_sys);
        o_command    <= code;
        o_command_wr <= 1'b1;
        @(posedge i_clk_sys);
        o_command_wr <= 1'b0;
        o_data_low   <= ~data[15:0];
        o_data_high  <= ~data[31:16];
        #1;
    endtask
    task automatic read(input logic [7:0] code, output logic [31:0] data, output logic ok);
        issue(code, 32'h0);
        ok   = i_read_valid;
        data = i_read_data;
    endtask
endmodule

// file: verification/testbench.sv
// testbench: command-port sequences with expected values for the parameter bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import apb_pkg::*;
    logic        clk, rst_n, pls_p, pls_m, enc_u, enc_d, fixed, absm, start, wr, rvalid;
    logic        decel, mtrig, seen;
    logic [15:0] dlo, dhi, lcfg, mcfg, cfg_o, ofs;
    logic [7:0]  cmd;
    logic [1:0]  hstep;
    logic [3:0]  mhit;
    logic [31:0] tgt, csrc, rdata, opls, arc, lup, llo, hspd;
    int          fails, n_compared, cyc;

    apb_axis_param_bank dut (
        .i_clk_sys(clk), .i_arst_n(rst_n), .i_data_low_port(dlo), .i_data_high_port(dhi),
        .i_command_port(cmd), .i_command_wr(wr), .i_limit_config_port(lcfg),
        .i_mode_config_port(mcfg), .i_pulse_plus(pls_p), .i_pulse_minus(pls_m),
        .i_enc_up(enc_u), .i_enc_dn(enc_d), .i_fixed_drive(fixed), .i_abs_mode(absm),
        .i_target_pulses(tgt), .i_drive_start(start), .i_homing_step(hstep),
        .i_compare_src(csrc), .o_read_data(rdata), .o_read_valid(rvalid),
        .o_decel_now(decel), .o_output_pulses(opls), .o_arc_center(arc),
        .o_limit_upper(lup), .o_limit_lower(llo), .o_limit_config(cfg_o),
        .o_accel_offset(ofs), .o_homing_speed(hspd), .o_match_hit(mhit), .o_match_trig(mtrig));
    apb_host_model host (.i_clk_sys(clk), .i_read_data(rdata), .i_read_valid(rvalid),
        .o_data_low(dlo), .o_data_high(dhi), .o_command(cmd), .o_command_wr(wr));

    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] code, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic        ok;
        host.read(code, d, ok);
        cmp_word({31'h0, ok}, 32'h1, "read strobe");
        cmp_word(d, exp, what);
    endtask
    task automatic pulse(input logic up, input int n);
        repeat (n) begin
            @(posedge clk);
            pls_p <= up;
            pls_m <= !up;
            @(posedge clk);
            pls_p <= 1'b0;
            pls_m <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    // encoder pins are asynchronous: hold each level long enough for the synchroniser
    task automatic enc(input logic up, input int n);
        repeat (n) begin
            @(posedge clk);
            enc_u <= up;
            enc_d <= !up;
            repeat (4) @(posedge clk);
            enc_u <= 1'b0;
            enc_d <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic kick;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic done(input string t);
        $display("test %s finished, mismatches so far %0d", t, fails);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            $display("ERROR %0t run did not finish in time", $time);
            give_verdict();
        end
    end

    initial begin
        {clk, rst_n, pls_p, pls_m, enc_u, enc_d, fixed, absm, start} = '0;
        {lcfg, mcfg, hstep, tgt, csrc} = '0;
        {fails, n_compared, cyc} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        cmp_word({16'h0, ofs}, 32'h0, "offset after reset");
        host.issue(CMD_LOGICAL_POS, 32'h0);
        pulse(1'b0, 1);
        rd_chk(CMD_RD_LOGICAL, 32'hffffffff, "no ring at reset max");
        done("reset");
        host.issue(CMD_LOGICAL_POS, 32'h7ffffffe);
        pulse(1'b1, 3);
        pulse(1'b0, 1);
        rd_chk(CMD_RD_LOGICAL, 32'h80000000, "logical count");
        host.issue(CMD_LOGICAL_MAX, 32'h5);
        host.issue(CMD_LOGICAL_POS, 32'h5);
        pulse(1'b1, 1);
        rd_chk(CMD_RD_LOGICAL, 32'h0, "logical wrap up");
        pulse(1'b0, 1);
        rd_chk(CMD_RD_LOGICAL, 32'h5, "logical wrap down");
        host.issue(CMD_LOGICAL_MAX, RING_MAX_RESET);
        done("logical counter");
        host.issue(CMD_REAL_POS, 32'h10);
        enc(1'b1, 3);
        enc(1'b0, 1);
        rd_chk(CMD_RD_REAL, 32'h12, "real count");
        host.issue(CMD_REAL_MAX, 32'h3);
        host.issue(CMD_REAL_POS, 32'h3);
        enc(1'b1, 1);
        rd_chk(CMD_RD_REAL, 32'h0, "real wrap up");
        enc(1'b0, 1);
        rd_chk(CMD_RD_REAL, 32'h3, "real wrap down");
        done("real counter");
        host.issue(CMD_LIMIT_UPPER, 32'h7fffffff);
        host.issue(CMD_LIMIT_LOWER, 32'h80000001);
        @(posedge clk);
        lcfg <= 16'h00a5;
        repeat (2) @(posedge clk);
        #1;
        cmp_word(lup, 32'h7fffffff, "upper limit");
        cmp_word(llo, 32'h80000001, "lower limit");
        cmp_word({16'h0, cfg_o}, 32'h00a5, "limit config");
        host.issue(CMD_ACCEL_OFFSET, 32'h5a5a8000);
        host.issue(CMD_ARC_CENTER, 32'hc0000001);
        cmp_word({16'h0, ofs}, 32'h8000, "accel offset");
        cmp_word(arc, 32'hc0000001, "arc centre");
        done("limits and offsets");
        @(posedge clk);
        csrc <= 32'h80000000;
        for (int i = 0; i < NUM_MATCH; i++)
            host.issue(CMD_MATCH_BASE + 8'(i), 32'(i * 5 - 2));
        for (int i = 0; i < NUM_MATCH; i++)
            rd_chk(CMD_RD_MATCH + 8'(i), 32'(i * 5 - 2), "match value");
        cmp_word({28'h0, mhit}, 32'h0, "no match at minimum");
        @(posedge clk);
        csrc <= 32'h5;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            seen = seen | mtrig;
        end
        cmp_word({28'h0, mhit}, 32'h3, "match results");
        cmp_word({31'h0, seen}, 32'h1, "match trigger");
        done("compare");
        host.issue(CMD_HOMING_SPEED, 32'd1000);
        @(posedge clk);
        hstep <= 2'd2;
        repeat (2) @(posedge clk);
        #1;
        cmp_word(hspd, 32'd1000, "homing speed step two");
        @(posedge clk);
        hstep <= 2'd1;
        repeat (2) @(posedge clk);
        #1;
        cmp_word(hspd, 32'h0, "homing speed step one");
        done("homing");
        @(posedge clk);
        tgt <= 32'hfffffff9;
        kick();
        cmp_word(opls, 32'd7, "relative output pulses");
        host.issue(CMD_LOGICAL_POS, 32'd10);
        host.issue(CMD_DECEL_POINT, 32'd3);
        @(posedge clk);
        tgt <= 32'd4;
        absm <= 1'b1;
        fixed <= 1'b1;
        mcfg <= 16'h0001;
        kick();
        cmp_word(opls, 32'd6, "absolute output pulses");
        pulse(1'b1, 2);
        cmp_word({31'h0, decel}, 32'h0, "decel before point");
        pulse(1'b1, 1);
        cmp_word({31'h0, decel}, 32'h1, "decel at point");
        @(posedge clk);
        mcfg <= 16'h0000;
        repeat (2) @(posedge clk);
        #1;
        cmp_word({31'h0, decel}, 32'h0, "decel without manual mode");
        done("fixed drive");
        give_verdict();
    end
endmodule
